// [logic/clock_output_stop_pkg.sv]
`default_nettype none
package clock_output_stop_pkg;
	// register map (byte addresses on the bus)
	localparam logic [11:0] CTRL_OFFSET   = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;

	// control word: four bits per differential output 0..3 (cpu0..cpu2, serial ref)
	localparam int          CFG_BITS       = 4;
	localparam int          DOT_OE_BIT     = 16;
	localparam int          DOT_PD_TRI_BIT = 17;
	localparam int          FREE_RUNNING_PCI_CLOCK_FREE_LSB  = 18;
	localparam logic [31:0] CTRL_RESET     = 32'h000d_1111;

	// status word
	localparam int STAT_OSC_BIT     = 0;
	localparam int STAT_RUN_BIT     = 1;
	localparam int STAT_STOPPED_LSB = 2;
	localparam int STAT_CPU_HALT    = 7;
	localparam int STAT_PCI_HALT    = 8;
	localparam int STAT_PD_BIT      = 9;

	// timing
	localparam int CLK_NS             = 20;
	localparam int STOP_DRIVE_NS      = 10;
	localparam int STOP_DRIVE_CYC     = (STOP_DRIVE_NS / CLK_NS) < 1 ? 1 : STOP_DRIVE_NS / CLK_NS;
	localparam int MIN_RESUME_PERIODS = 2;
	localparam int MAX_RESUME_PERIODS = 6;
	localparam int RESUME_TICKS       = 2 * MIN_RESUME_PERIODS + 1;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef enum logic [1:0] {STR_NORMAL, STR_REFERENCE_CURRENT_X6, STR_REFERENCE_CURRENT_X2} drive_t;
	typedef enum logic [1:0] {PD_RUN, PD_DRAIN, PD_OFF, PD_WAKE} pd_state_t;

	typedef struct packed {
		logic free_run;
		logic stop_tri;
		logic pd_tri;
		logic oe;
	} diff_cfg_t;

	typedef struct packed {
		logic   clk_true;
		logic   clk_comp;
		logic   true_oe_n;
		logic   comp_oe_n;
		drive_t strength;
	} diff_out_t;
endpackage : clock_output_stop_pkg
`default_nettype wire

// [logic/clock_output_stop_powerdown.sv]
`timescale 1ns/10ps
`default_nettype none
module clock_output_stop_powerdown
	import clock_output_stop_pkg::*;
#(
	parameter int CPU_HALF   = 1,
	parameter int PCI_HALF   = 3,
	parameter int PCI_COUNT  = 6,
	parameter int OSC_SETTLE = 16
) (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output var  logic                 hreadyout,
	output var  logic                 hresp,
	output var  logic [31:0]          hrdata,
	input  wire logic                 cpu_halt_n,
	input  wire logic                 pci_halt_n,
	input  wire logic                 powerdown_request,
	output wire diff_out_t [2:0]      cpu_out,
	output wire diff_out_t            serial_ref_clock,
	output wire diff_out_t            display_clock_96,
	output wire logic [PCI_COUNT-1:0] pci_clk,
	output wire logic [1:0]           free_running_pci_clock,
	output wire logic                 usb_clk,
	output wire logic                 ref_clk,
	output var  logic                 osc_enable
);
	localparam int N_DIFF = 5;
	localparam int N_SE   = PCI_COUNT + 4;

	if (CPU_HALF < 1 || PCI_HALF < 1 || PCI_COUNT < 1 || OSC_SETTLE < 1) begin : g_check
		$error("clock_output_stop_powerdown: parameters must be at least one");
	end

	logic [31:0]       ctrl_q;
	logic              cpu_halt_q;
	logic              pci_halt_q;
	pd_state_t         pd_state_q;
	logic [15:0]       settle_q;
	logic              run_en;
	logic              pd_active;
	logic [15:0]       fast_cnt_q;
	logic [15:0]       slow_cnt_q;
	logic              fast_tick;
	logic              slow_tick;
	logic              wr_pend_q;
	logic [11:0]       addr_q;
	logic [N_DIFF-1:0] tru_q;
	logic [N_DIFF-1:0] cmp_q;
	logic [N_DIFF-1:0] stop_q;
	logic [N_DIFF-1:0] tru_oe_n_q;
	logic [N_DIFF-1:0] cmp_oe_n_q;
	drive_t            str_q [N_DIFF];
	logic [N_SE-1:0]   se_q;

	assign run_en    = (pd_state_q == PD_RUN);
	assign pd_active = powerdown_request | ~run_en;
	assign fast_tick = run_en && (fast_cnt_q == 16'(CPU_HALF - 1));
	assign slow_tick = run_en && (slow_cnt_q == 16'(PCI_HALF - 1));

	// halt inputs are taken as synchronous; one register keeps decode off the raw pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_halt_q <= 1'b0;
			pci_halt_q <= 1'b0;
		end else begin
			cpu_halt_q <= ~cpu_halt_n;
			pci_halt_q <= ~pci_halt_n;
		end
	end

	// power-down sequencing: outputs are already low before the oscillator is dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pd_state_q <= PD_RUN;
			osc_enable <= 1'b1;
			settle_q   <= 16'h0000;
		end else begin
			case (pd_state_q)
				PD_RUN: begin
					if (powerdown_request) begin
						pd_state_q <= PD_DRAIN;
					end
				end
				PD_DRAIN: begin
					osc_enable <= 1'b0;
					pd_state_q <= PD_OFF;
				end
				PD_OFF: begin
					if (!powerdown_request) begin
						osc_enable <= 1'b1;
						settle_q   <= 16'h0000;
						pd_state_q <= PD_WAKE;
					end
				end
				PD_WAKE: begin
					if (powerdown_request) begin
						pd_state_q <= PD_DRAIN;
					end else if (settle_q == 16'(OSC_SETTLE - 1)) begin
						pd_state_q <= PD_RUN;
					end else begin
						settle_q <= settle_q + 16'h0001;
					end
				end
				default: pd_state_q <= PD_RUN;
			endcase
		end
	end

	// dividers restart from zero so the first edge after wake is a full half period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fast_cnt_q <= 16'h0000;
			slow_cnt_q <= 16'h0000;
		end else if (!run_en) begin
			fast_cnt_q <= 16'h0000;
			slow_cnt_q <= 16'h0000;
		end else begin
			fast_cnt_q <= fast_tick ? 16'h0000 : fast_cnt_q + 16'h0001;
			slow_cnt_q <= slow_tick ? 16'h0000 : slow_cnt_q + 16'h0001;
		end
	end

	// differential outputs: 0..2 cpu, 3 serial ref, 4 display clock
	for (genvar i = 0; i < N_DIFF; i++) begin : g_diff
		diff_cfg_t  cfg;
		logic       halt;
		logic       stoppable;
		logic [3:0] wait_q;

		if (i < 4) begin : g_cfg
			assign cfg = ctrl_q[CFG_BITS*i +: CFG_BITS];
		end else begin : g_dot
			assign cfg = '{free_run: 1'b1, stop_tri: 1'b0,
				pd_tri: ctrl_q[DOT_PD_TRI_BIT], oe: ctrl_q[DOT_OE_BIT]};
		end
		assign halt      = (i < 3) ? cpu_halt_q : ((i == 3) ? pci_halt_q : 1'b0);
		assign stoppable = ~cfg.free_run;

		// clock levels: power-down clears them at once, no clock edge needed
		always_ff @(posedge hclk or negedge hresetn or posedge powerdown_request) begin
			if (!hresetn) begin
				tru_q[i]  <= 1'b0;
				cmp_q[i]  <= 1'b1;
				stop_q[i] <= 1'b0;
				wait_q    <= 4'h0;
			end else if (powerdown_request) begin
				tru_q[i]  <= 1'b0;
				cmp_q[i]  <= 1'b0;
				stop_q[i] <= 1'b0;
				wait_q    <= 4'h0;
			end else if (!run_en) begin
				tru_q[i] <= 1'b0;
				cmp_q[i] <= 1'b0;
			end else if (halt && stoppable) begin
				wait_q <= 4'h0;
				if (!stop_q[i] && fast_tick) begin
					tru_q[i]  <= 1'b1;
					cmp_q[i]  <= 1'b0;
					stop_q[i] <= 1'b1;
				end
			end else if (stop_q[i]) begin
				if (fast_tick) begin
					if (wait_q == 4'(RESUME_TICKS - 1)) begin
						stop_q[i] <= 1'b0;
						tru_q[i]  <= 1'b0;
						cmp_q[i]  <= 1'b1;
					end else begin
						wait_q <= wait_q + 4'h1;
					end
				end
			end else if (fast_tick) begin
				tru_q[i] <= ~tru_q[i];
				cmp_q[i] <= tru_q[i];
			end
		end

		// drive strength and enables
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				tru_oe_n_q[i] <= 1'b1;
				cmp_oe_n_q[i] <= 1'b1;
				str_q[i]      <= STR_NORMAL;
			end else if (!cfg.oe) begin
				tru_oe_n_q[i] <= 1'b1;
				cmp_oe_n_q[i] <= 1'b1;
				str_q[i]      <= STR_NORMAL;
			end else if (pd_active) begin
				tru_oe_n_q[i] <= cfg.pd_tri;
				cmp_oe_n_q[i] <= 1'b1;
				str_q[i]      <= STR_REFERENCE_CURRENT_X2;
			end else if (stop_q[i] || (halt && stoppable)) begin
				// once halt drops a tristated output is driven high again at once
				tru_oe_n_q[i] <= cfg.stop_tri & halt;
				cmp_oe_n_q[i] <= cfg.stop_tri & halt;
				str_q[i]      <= STR_REFERENCE_CURRENT_X6;
			end else begin
				tru_oe_n_q[i] <= 1'b0;
				cmp_oe_n_q[i] <= 1'b0;
				str_q[i]      <= STR_NORMAL;
			end
		end
	end

	// single-ended: pci, free-running pci, usb, ref
	for (genvar j = 0; j < N_SE; j++) begin : g_se
		logic stoppable;
		if (j < PCI_COUNT) begin : g_pci
			assign stoppable = 1'b1;
		end else if (j < PCI_COUNT + 2) begin : g_free_running_pci_clock
			assign stoppable = ~ctrl_q[FREE_RUNNING_PCI_CLOCK_FREE_LSB + j - PCI_COUNT];
		end else begin : g_free
			assign stoppable = 1'b0;
		end

		always_ff @(posedge hclk or negedge hresetn or posedge powerdown_request) begin
			if (!hresetn) begin
				se_q[j] <= 1'b0;
			end else if (powerdown_request) begin
				se_q[j] <= 1'b0;
			end else if (!run_en) begin
				se_q[j] <= 1'b0;
			end else if (slow_tick && !(pci_halt_q && stoppable && !se_q[j])) begin
				// a halted clock finishes its high phase and then stays low
				se_q[j] <= ~se_q[j];
			end
		end
	end

	for (genvar k = 0; k < 3; k++) begin : g_cpu_out
		assign cpu_out[k] = '{tru_q[k], cmp_q[k], tru_oe_n_q[k], cmp_oe_n_q[k], str_q[k]};
	end
	assign serial_ref_clock       = '{tru_q[3], cmp_q[3], tru_oe_n_q[3], cmp_oe_n_q[3], str_q[3]};
	assign display_clock_96       = '{tru_q[4], cmp_q[4], tru_oe_n_q[4], cmp_oe_n_q[4], str_q[4]};
	assign pci_clk                = se_q[PCI_COUNT-1:0];
	assign free_running_pci_clock = se_q[PCI_COUNT+1:PCI_COUNT];
	assign usb_clk                = se_q[PCI_COUNT+2];
	assign ref_clk                = se_q[PCI_COUNT+3];

	// bus slave: zero wait states, always okay; any write to ctrl loads the whole word, hsize is ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q    <= 12'h000;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
			if (hready && hsel && htrans == HTRANS_NONSEQ) begin
				wr_pend_q <= hwrite;
				addr_q    <= haddr[11:0];
				if (hwrite) begin
					hrdata <= 32'h0000_0000;
				end else if (haddr[11:0] == CTRL_OFFSET) begin
					hrdata <= ctrl_q;
				end else if (haddr[11:0] == STATUS_OFFSET) begin
					hrdata <= {22'h000000, powerdown_request, pci_halt_q, cpu_halt_q,
						stop_q, run_en, osc_enable};
				end else begin
					hrdata <= 32'h0000_0000;
				end
			end else begin
				wr_pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_pend_q && addr_q == CTRL_OFFSET) begin
			ctrl_q <= hwdata;
		end
	end
endmodule : clock_output_stop_powerdown
`default_nettype wire

// [dv/clock_output_stop_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module clock_output_stop_sva
	import clock_output_stop_pkg::*;
#(
	parameter int PCI_COUNT = 6
) (
	input wire logic                 hclk,
	input wire logic                 hresetn,
	input wire logic                 hresp,
	input wire logic                 cpu_halt_n,
	input wire logic                 pci_halt_n,
	input wire logic                 powerdown_request,
	input wire diff_out_t [2:0]      cpu_out,
	input wire diff_out_t            serial_ref_clock,
	input wire diff_out_t            display_clock_96,
	input wire logic [PCI_COUNT-1:0] pci_clk,
	input wire logic                 usb_clk,
	input wire logic                 ref_clk,
	input wire logic                 osc_enable
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("bus response not okay");
	a_pd_low: assert property (powerdown_request |-> pci_clk == '0 && !usb_clk && !ref_clk)
		else $error("single-ended clock high in power-down");
	a_osc_after_clocks: assert property (!osc_enable |-> pci_clk == '0 && !cpu_out[0].clk_true
		&& !cpu_out[1].clk_true && !cpu_out[2].clk_true) else $error("oscillator off with clock high");
	a_osc_off_late: assert property ($rose(powerdown_request) |-> ##[1:3] !osc_enable)
		else $error("oscillator not stopped");
	a_comp_float: assert property (powerdown_request[*2] |-> cpu_out[0].comp_oe_n && cpu_out[1].comp_oe_n
		&& cpu_out[2].comp_oe_n && serial_ref_clock.comp_oe_n && display_clock_96.comp_oe_n)
		else $error("complement driven in power-down");
	a_pd_times_two: assert property (powerdown_request[*2] ##0 !cpu_out[1].true_oe_n
		|-> cpu_out[1].strength == STR_REFERENCE_CURRENT_X2) else $error("power-down strength wrong");
	a_halt_hold: assert property ((!cpu_halt_n && !powerdown_request && osc_enable)[*6]
		##0 cpu_out[0].strength == STR_REFERENCE_CURRENT_X6 |-> cpu_out[0].clk_true && !cpu_out[0].clk_comp)
		else $error("halted output not held true high");
	a_resume_window: assert property ($rose(cpu_halt_n) && !powerdown_request && osc_enable
		&& cpu_out[0].clk_true && cpu_out[0].strength == STR_REFERENCE_CURRENT_X6
		|-> cpu_out[0].clk_true[*4] ##[1:8] !cpu_out[0].clk_true) else $error("resume outside window");
	a_src_hold: assert property ((!pci_halt_n && !powerdown_request && osc_enable)[*6]
		##0 serial_ref_clock.strength == STR_REFERENCE_CURRENT_X6 |-> !serial_ref_clock.clk_comp)
		else $error("serial ref complement not low");
endmodule : clock_output_stop_sva
bind clock_output_stop_powerdown clock_output_stop_sva #(.PCI_COUNT(PCI_COUNT)) u_sva (.hclk, .hresetn,
	.hresp, .cpu_halt_n, .pci_halt_n, .powerdown_request, .cpu_out, .serial_ref_clock,
	.display_clock_96, .pci_clk, .usb_clk, .ref_clk, .osc_enable);
`default_nettype wire

// [dv/pm_partner.sv]
`timescale 1ns/10ps
`default_nettype none
module pm_partner (
	input  wire logic hclk,
	input  wire logic want_cpu_halt,
	input  wire logic want_pci_halt,
	input  wire logic want_pd,
	output var  logic cpu_halt_n,
	output var  logic pci_halt_n,
	output var  logic powerdown_request
);
	initial begin
		cpu_halt_n = 1'b1;
		pci_halt_n = 1'b1;
		powerdown_request = 1'b0;
	end
	// pins move away from the clock edge, as a real chipset may
	always @(posedge hclk) begin
		cpu_halt_n <= #7 !want_cpu_halt;
		pci_halt_n <= #7 !want_pci_halt;
		powerdown_request <= #13 want_pd;
	end
endmodule : pm_partner
`default_nettype wire

// [dv/clock_output_stop_powerdown_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module clock_output_stop_powerdown_tb
	import clock_output_stop_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, want_cpu = 0, want_pci = 0, want_pd = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, v;
	logic [1:0] htrans = 0, free_running_pci_clock;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, usb_clk, ref_clk, osc_enable, cpu_halt_n, pci_halt_n, powerdown_request;
	wire logic hready;
	diff_out_t [2:0] cpu_out;
	diff_out_t serial_ref_clock, display_clock_96;
	logic [5:0] pci_clk;
	int failures = 0, n_compared = 0, n;
	assign hready = hreadyout;
	always #10 hclk = !hclk;
	clock_output_stop_powerdown #(.OSC_SETTLE(4)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .cpu_halt_n, .pci_halt_n, .powerdown_request,
		.cpu_out, .serial_ref_clock, .display_clock_96, .pci_clk, .free_running_pci_clock, .usb_clk,
		.ref_clk, .osc_enable);
	pm_partner pm (.hclk, .want_cpu_halt(want_cpu), .want_pci_halt(want_pci), .want_pd(want_pd),
		.cpu_halt_n, .pci_halt_n, .powerdown_request);
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
		int k;
		k = 0;
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 20);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 40);
		rd = hrdata;
		if (k >= 40) begin
			failures++;
			end_of_test;
		end
	endtask : xfer
	initial begin
		repeat (5000) @(posedge hclk);
		failures++;
		end_of_test;
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(CTRL_OFFSET, 0, 0, v); check("ctrl reset", v, CTRL_RESET);
		xfer(32'h10, 1, 32'hffff_ffff, v);
		xfer(32'h10, 0, 0, v); check("unmapped", v, 32'h0);
		xfer(STATUS_OFFSET, 0, 0, v); check("osc on", v[STAT_OSC_BIT], 1);
		$display("test registers done");
		// cpu0 stoppable, cpu1 tristates when halted, cpu2 free-running
		xfer(CTRL_OFFSET, 1, 32'h000d_1951, v);
		xfer(CTRL_OFFSET, 0, 0, v); check("ctrl rw", v, 32'h000d_1951);
		want_cpu <= 1'b1;
		want_pci <= 1'b1;
		repeat (12) @(posedge hclk);
		check("cpu0 held", {cpu_out[0].clk_true, cpu_out[0].clk_comp, cpu_out[0].strength}, 4'h9);
		check("cpu1 float", cpu_out[1].true_oe_n, 1);
		check("cpu2 runs", cpu_out[2].strength, STR_NORMAL);
		check("src held", {serial_ref_clock.clk_comp, serial_ref_clock.strength}, 3'h1);
		check("dot runs", display_clock_96.strength, STR_NORMAL);
		xfer(STATUS_OFFSET, 0, 0, v); check("halt seen", v[STAT_CPU_HALT], 1);
		want_cpu <= 1'b0;
		want_pci <= 1'b0;
		for (n = 0; n < 8 && cpu_out[1].true_oe_n !== 1'b0; n++) @(posedge hclk);
		check("cpu1 driven soon", n <= 4, 1);
		for (n = 0; n < 20 && cpu_out[0].strength !== STR_NORMAL; n++) @(posedge hclk);
		check("cpu0 resumed", n < 20, 1);
		$display("test halt done");
		// cpu0 floats in power-down, cpu1 drives at x2, display clock floats
		xfer(CTRL_OFFSET, 1, 32'h000f_1953, v);
		want_pd <= 1'b1;
		repeat (6) @(posedge hclk);
		check("cpu0 pd float", cpu_out[0].true_oe_n, 1);
		check("cpu1 pd x2", {cpu_out[1].true_oe_n, cpu_out[1].strength}, 3'h2);
		check("src pd x2", serial_ref_clock.strength, STR_REFERENCE_CURRENT_X2);
		check("dot pd float", display_clock_96.true_oe_n, 1);
		check("se low", {pci_clk, free_running_pci_clock, usb_clk, ref_clk}, 0);
		check("osc off", osc_enable, 0);
		xfer(STATUS_OFFSET, 0, 0, v); check("pd seen", v[STAT_PD_BIT], 1);
		want_pd <= 1'b0;
		for (n = 0; n < 60 && pci_clk[0] !== 1'b1; n++) @(posedge hclk);
		check("pci restart", n < 60, 1);
		$display("test power-down done");
		xfer(CTRL_OFFSET, 1, 32'h000f_1950, v);
		repeat (4) @(posedge hclk);
		check("cpu0 off", {cpu_out[0].true_oe_n, cpu_out[0].comp_oe_n}, 2'h3);
		want_cpu <= 1'b1;
		repeat (10) @(posedge hclk);
		check("cpu0 off halted", {cpu_out[0].true_oe_n, cpu_out[0].comp_oe_n}, 2'h3);
		want_cpu <= 1'b0;
		$display("test disable done");
		end_of_test;
	end
endmodule : clock_output_stop_powerdown_tb
`default_nettype wire
